// ---- design/tmop_pkg.sv ----
// Constants, encodings and carrier structs for the meter output processor.
// Assumes a 50 MHz system clock and 16-bit two's complement measurement words.
package tmop_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TENTH_SEC_MS    = 100;
  localparam int unsigned TENTH_CYC       = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam int unsigned SEC_TENTHS      = 10;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_INPUT_CFG  = 8'h00;
  localparam logic [7:0] ADDR_LOOP_CFG   = 8'h04;
  localparam logic [7:0] ADDR_ANCHORS    = 8'h08;
  localparam logic [7:0] ADDR_LIMITS     = 8'h0C;
  localparam logic [7:0] ADDR_HOLD_CFG   = 8'h10;
  localparam logic [7:0] ADDR_SECURITY   = 8'h14;
  localparam logic [7:0] ADDR_BUS_CMD    = 8'h18;
  localparam logic [7:0] ADDR_STATUS     = 8'h1C;
  localparam logic [7:0] ADDR_VALUES     = 8'h20;
  localparam logic [7:0] ADDR_LOOP_OUT   = 8'h24;
  localparam logic [7:0] ADDR_UNLOCK     = 8'h28;

  // Field positions of the input configuration word.
  localparam int unsigned F_KIND    = 0;   // [3:0]
  localparam int unsigned F_SCALE   = 4;
  localparam int unsigned F_RES     = 5;
  localparam int unsigned F_SMOOTH  = 8;   // [10:8]
  localparam int unsigned F_SHIFT   = 16;  // [23:16] signed
  // Loop configuration word.
  localparam int unsigned F_LMODE   = 0;   // [1:0]
  localparam int unsigned F_FAULT   = 2;   // [3:2]
  localparam int unsigned F_SILENCE = 8;   // [14:8]
  // Hold configuration word.
  localparam int unsigned F_HINV    = 0;
  localparam int unsigned F_SHOWSEL = 1;
  localparam int unsigned F_R1SEL   = 2;
  localparam int unsigned F_R2SEL   = 3;
  localparam int unsigned F_LOOPSEL = 4;
  localparam int unsigned F_HTIME   = 8;   // [15:8] tenths of a second
  localparam int unsigned F_SWING   = 16;  // [31:16]
  // Security word.
  localparam int unsigned F_PASS    = 0;   // [15:0] four BCD digits
  localparam int unsigned F_R1UNL   = 16;
  localparam int unsigned F_R2UNL   = 17;

  // Setting limits.
  localparam logic [3:0]  KIND_VOLT     = 4'h8;
  localparam logic [2:0]  SMOOTH_MAX    = 3'h5;
  localparam logic signed [7:0] SHIFT_MAX = 8'sd99;
  localparam logic [8:0]  LO_PCT_MAX    = 9'h12B;   // 29.9 percent in tenths
  localparam logic [8:0]  HI_PCT_MAX    = 9'h0C7;   // 19.9 percent in tenths
  localparam logic [7:0]  HTIME_MAX     = 8'hC7;    // 19.9 s in tenths
  localparam logic [6:0]  SILENCE_MAX   = 7'h63;    // 99 s
  localparam logic [15:0] PASS_OFF      = 16'h0000;

  // Loop currents in microamps.
  localparam logic [15:0] UA_IDLE   = 16'h09C4;  // 2500
  localparam logic [15:0] UA_4MA    = 16'h0FA0;  // 4000
  localparam logic [15:0] UA_20MA   = 16'h4E20;  // 20000
  localparam logic [15:0] UA_SPAN   = 16'h3E80;  // 16000
  localparam logic [15:0] UA_FLOOR  = 16'h0AF0;  // 2800
  localparam logic [15:0] UA_CEIL   = 16'h5DC0;  // 24000
  localparam logic [15:0] UA_HIGHF  = 16'h5654;  // 22100
  localparam logic [15:0] UA_LOWF   = 16'h0D48;  // 3400

  // Span limits per sensor kind, in tenths of a degree Celsius or 0.01 mV.
  localparam logic signed [15:0] KIND_LO [9] = '{
    -16'sd2000, -16'sd500, -16'sd2100, -16'sd2000, -16'sd2000,
    -16'sd500, 16'sd2500, -16'sd2000, -16'sd1000};
  localparam logic signed [15:0] KIND_HI [9] = '{
    16'sd13700, 16'sd17680, 16'sd12000, 16'sd4000, 16'sd13000,
    16'sd17680, 16'sd18200, 16'sd10000, 16'sd9000};
  localparam logic signed [15:0] DEC_LIMIT = 16'sd9999;

  typedef enum logic [1:0] {
    TMOP_LOOP_OFF  = 2'h0,
    TMOP_LOOP_4_20 = 2'h1,
    TMOP_LOOP_BUS  = 2'h2
  } tmop_loop_mode_e;

  typedef enum logic [1:0] {
    TMOP_FAULT_KEEP = 2'h0,
    TMOP_FAULT_HIGH = 2'h1,
    TMOP_FAULT_LOW  = 2'h2
  } tmop_fault_e;

  typedef enum logic [2:0] {
    TMOP_TRK_IDLE  = 3'b001,
    TMOP_TRK_SWING = 3'b010,
    TMOP_TRK_HOLD  = 3'b100
  } tmop_track_e;

  // Raw sample from the front end.
  typedef struct packed {
    logic               valid;
    logic signed [15:0] value;   // Tenths of a degree C, or 0.01 mV.
  } tmop_sample_s;

  // Values routed to the consumers.
  typedef struct packed {
    logic signed [15:0] shown;
    logic signed [15:0] relay1;
    logic signed [15:0] relay2;
  } tmop_route_s;

endpackage

// ---- design/tmop_core.sv ----
// Output processor of a thermocouple panel meter with an APB register slave.
// Assumes the front end supplies one compensated sample per valid pulse, and
// that the serial receiver pulses frame_seen_in for every frame it accepts.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tmop_core
  import tmop_pkg::*;
(
  // Clock and reset.
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  // APB slave.
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [7:0]         paddr_in,
  input  wire logic [31:0]        pwdata_in,
  output logic      [31:0]        prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  // Front end and panel.
  input  wire tmop_sample_s       sample_in,
  input  wire logic               frame_seen_in,
  input  wire logic               escape_key_in,
  input  wire logic [15:0]        entered_code_in,
  // Routed results.
  output tmop_route_s             route_out,
  output logic                    result_valid_out,
  output logic                    range_fault_out,
  output logic [15:0]             loop_ua_out,
  output logic                    menu_open_out,
  output logic [1:0]              threshold_edit_ok_out
);

  // Configuration registers.
  logic [31:0] input_cfg_r;
  logic [31:0] loop_cfg_r;
  logic [31:0] anchors_r;
  logic [31:0] limits_r;
  logic [31:0] hold_cfg_r;
  logic [31:0] security_r;
  logic [15:0] bus_cmd_r;
  logic        code_ok_r;

  logic [3:0]        kind;
  logic              volt;
  logic [2:0]        smooth;
  logic signed [7:0] shift;
  assign kind   = input_cfg_r[F_KIND +: 4];
  assign volt   = (kind == KIND_VOLT);
  assign smooth = input_cfg_r[F_SMOOTH +: 3];
  assign shift  = input_cfg_r[F_SHIFT +: 8];

  // APB decode; the slave always answers in the access cycle.
  logic apb_wr;
  logic apb_rd;
  logic bad_addr;
  assign apb_wr      = psel_in && penable_in && pwrite_in;
  assign apb_rd      = psel_in && penable_in && !pwrite_in;
  assign pready_out  = 1'b1;
  assign bad_addr    = (paddr_in[1:0] != 2'h0) || (paddr_in > ADDR_UNLOCK);
  assign pslverr_out = psel_in && penable_in && bad_addr;

  // Configuration writes; out-of-range limits are saturated, not refused; loop mode and fault codes are stored as written.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      input_cfg_r <= 32'h0000_0000;
      loop_cfg_r  <= 32'h0000_0001;
      anchors_r   <= 32'h2710_0000;
      limits_r    <= 32'h0000_0000;
      hold_cfg_r  <= 32'h0000_0000;
      security_r  <= 32'h0000_0000;
      bus_cmd_r   <= 16'h0FA0;
    end else if (apb_wr && !bad_addr) begin
      unique case (paddr_in)
        ADDR_INPUT_CFG: begin
          input_cfg_r[F_KIND +: 4] <= (pwdata_in[F_KIND +: 4] > KIND_VOLT) ?
                                      KIND_VOLT : pwdata_in[F_KIND +: 4];
          input_cfg_r[F_SCALE]     <= pwdata_in[F_SCALE];
          input_cfg_r[F_RES]       <= pwdata_in[F_RES];
          input_cfg_r[F_SMOOTH +: 3] <= (pwdata_in[F_SMOOTH +: 3] > SMOOTH_MAX) ?
                                        SMOOTH_MAX : pwdata_in[F_SMOOTH +: 3];
          if ($signed(pwdata_in[F_SHIFT +: 8]) > SHIFT_MAX) begin
            input_cfg_r[F_SHIFT +: 8] <= SHIFT_MAX;
          end else if ($signed(pwdata_in[F_SHIFT +: 8]) < -SHIFT_MAX) begin
            input_cfg_r[F_SHIFT +: 8] <= -SHIFT_MAX;
          end else begin
            input_cfg_r[F_SHIFT +: 8] <= pwdata_in[F_SHIFT +: 8];
          end
        end
        ADDR_LOOP_CFG: begin
          loop_cfg_r[3:0] <= pwdata_in[3:0];
          loop_cfg_r[F_SILENCE +: 7] <= (pwdata_in[F_SILENCE +: 7] > SILENCE_MAX) ?
                                        SILENCE_MAX : pwdata_in[F_SILENCE +: 7];
        end
        ADDR_ANCHORS: anchors_r <= pwdata_in;
        ADDR_LIMITS: begin
          limits_r[8:0]   <= (pwdata_in[8:0] > LO_PCT_MAX) ? LO_PCT_MAX : pwdata_in[8:0];
          limits_r[24:16] <= (pwdata_in[24:16] > HI_PCT_MAX) ? HI_PCT_MAX : pwdata_in[24:16];
        end
        ADDR_HOLD_CFG: begin
          hold_cfg_r[7:0]   <= pwdata_in[7:0];
          hold_cfg_r[15:8]  <= (pwdata_in[15:8] > HTIME_MAX) ? HTIME_MAX : pwdata_in[15:8];
          hold_cfg_r[31:16] <= pwdata_in[31:16];
        end
        ADDR_SECURITY: security_r[17:0] <= pwdata_in[17:0];
        ADDR_BUS_CMD:  bus_cmd_r <= pwdata_in[15:0];
        default: ;
      endcase
    end
  end

  // Passcode check latches the entered code comparison when the unlock register is written over APB.
  // zero code disables check
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      code_ok_r <= 1'b0;
    end else if (apb_wr && paddr_in == ADDR_UNLOCK) begin
      code_ok_r <= (entered_code_in == security_r[F_PASS +: 16]);
    end else if (escape_key_in) begin
      code_ok_r <= 1'b0;
    end
  end
  assign menu_open_out = (security_r[F_PASS +: 16] == PASS_OFF) || code_ok_r;
  assign threshold_edit_ok_out = {security_r[F_R2UNL] | menu_open_out,
                                  security_r[F_R1UNL] | menu_open_out};

  // Conversion: scale, resolution and shift apply to thermocouples only.
  logic signed [19:0] conv_raw;
  logic signed [19:0] conv_f;
  logic signed [19:0] conv_val;
  always_comb begin
    conv_raw = 20'(sample_in.value);
    // Fahrenheit is 1.8 C + 32
    conv_f = input_cfg_r[F_SCALE] ? 20'((conv_raw * 9) / 5 + 320) : conv_raw;
    conv_val = conv_f + 20'(shift) * 20'sd10;
    if (volt) begin
      conv_val = conv_raw;
    end
  end

  // Out-of-span and out-of-display detection.
  logic out_of_span;
  logic [3:0] kidx;
  assign kidx = (kind > KIND_VOLT) ? KIND_VOLT : kind;
  assign out_of_span = (sample_in.value < KIND_LO[kidx]) ||
                       (sample_in.value > KIND_HI[kidx]) ||
                       (!volt && input_cfg_r[F_RES] &&
                        (conv_val > 20'(DEC_LIMIT) || conv_val < -20'(DEC_LIMIT)));

  // Exponential smoother: weight 1/2^level; level 5 spans about 2 s at 16 Hz.
  logic signed [23:0] smoothing_level_r;
  logic signed [15:0] live_r;
  logic               new_r;
  logic               fault_r;
  logic signed [23:0] smoothing_level_nxt;
  // Next filter state; the result register takes it, so a result never lags a sample.
  always_comb begin
    if (smooth == 3'h0) begin
      smoothing_level_nxt = 24'(conv_val) <<< 5;
    end else begin
      smoothing_level_nxt = smoothing_level_r + (((24'(conv_val) <<< 5) - smoothing_level_r) >>> smooth);
    end
  end
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      smoothing_level_r  <= 24'sh000000;
      live_r  <= 16'sh0000;
      new_r   <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      new_r <= sample_in.valid;
      if (sample_in.valid) begin
        smoothing_level_r <= smoothing_level_nxt;
        if (!volt && !input_cfg_r[F_RES]) begin
          live_r <= 16'((((smoothing_level_nxt >>> 5) / 10) * 10));
        end else begin
          live_r <= 16'(smoothing_level_nxt >>> 5);
        end
        fault_r <= out_of_span;
      end
    end
  end
  assign result_valid_out = new_r;
  assign range_fault_out  = fault_r;

  // Peak tracker with timed hold.
  tmop_track_e        trk_r;
  logic signed [15:0] ext_r;
  logic signed [15:0] held_r;
  logic               held_ok_r;
  logic [7:0]         hold_left_r;
  logic [23:0]        tenth_cnt_r;
  logic               tenth_tick;
  logic               inv;
  logic signed [16:0] swing;
  logic signed [16:0] min_sw;
  assign inv        = hold_cfg_r[F_HINV];
  assign tenth_tick = (tenth_cnt_r == 24'(TENTH_CYC - 1));
  assign min_sw     = 17'($signed({1'b0, hold_cfg_r[F_SWING +: 16]}));
  assign swing      = inv ? 17'(live_r) - 17'(ext_r) : 17'(ext_r) - 17'(live_r);

  // Shared one-tenth-second divider.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      tenth_cnt_r <= 24'h000000;
    end else begin
      tenth_cnt_r <= tenth_tick ? 24'h000000 : tenth_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      trk_r       <= TMOP_TRK_IDLE;
      ext_r       <= 16'sh0000;
      held_r      <= 16'sh0000;
      held_ok_r   <= 1'b0;
      hold_left_r <= 8'h00;
    end else begin
      unique case (trk_r)
        TMOP_TRK_IDLE: begin
          if (new_r) begin
            ext_r <= live_r;
            trk_r <= TMOP_TRK_SWING;
          end
        end
        TMOP_TRK_SWING: begin
          if (new_r) begin
            if (inv ? (live_r < ext_r) : (live_r > ext_r)) begin
              ext_r <= live_r;
            end else if (swing >= min_sw) begin
              held_r      <= ext_r;
              held_ok_r   <= 1'b1;
              hold_left_r <= hold_cfg_r[F_HTIME +: 8];
              ext_r       <= live_r;
              trk_r       <= TMOP_TRK_HOLD;
            end
          end
        end
        TMOP_TRK_HOLD: begin
          if (hold_cfg_r[F_HTIME +: 8] == 8'h00) begin
            if (!hold_cfg_r[F_SHOWSEL] || escape_key_in) begin
              held_ok_r <= 1'b0;
              trk_r     <= TMOP_TRK_IDLE;
            end
          end else if (tenth_tick) begin
            if (hold_left_r <= 8'h01) begin
              held_ok_r <= 1'b0;
              trk_r     <= TMOP_TRK_IDLE;
            end else begin
              hold_left_r <= hold_left_r - 8'h01;
            end
          end
        end
        default: trk_r <= TMOP_TRK_IDLE;
      endcase
    end
  end

  // Source selection; without a held value the live value is used.
  logic signed [15:0] peak_v;
  logic signed [15:0] loop_src;
  assign peak_v = held_ok_r ? held_r : live_r;
  assign loop_src = hold_cfg_r[F_LOOPSEL] ? peak_v : live_r;

  // Route registers to display and relays.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      route_out <= '0;
    end else begin
      route_out.shown  <= hold_cfg_r[F_SHOWSEL] ? peak_v : live_r;
      route_out.relay1 <= hold_cfg_r[F_R1SEL] ? peak_v : live_r;
      route_out.relay2 <= hold_cfg_r[F_R2SEL] ? peak_v : live_r;
    end
  end

  // Bus silence supervision in whole seconds.
  logic [3:0]  sec_div_r;
  logic [6:0]  silent_s_r;
  logic        silence;
  logic [6:0]  sil_lim;
  assign sil_lim = loop_cfg_r[F_SILENCE +: 7];
  assign silence = (sil_lim != 7'h00) && (silent_s_r >= sil_lim);
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sec_div_r  <= 4'h0;
      silent_s_r <= 7'h00;
    end else if (frame_seen_in) begin
      sec_div_r  <= 4'h0;
      silent_s_r <= 7'h00;
    end else if (tenth_tick) begin
      if (sec_div_r == 4'(SEC_TENTHS - 1)) begin
        sec_div_r <= 4'h0;
        if (silent_s_r != 7'h7F) begin
          silent_s_r <= silent_s_r + 7'h01;
        end
      end else begin
        sec_div_r <= sec_div_r + 4'h1;
      end
    end
  end

  // Loop current computation.
  tmop_loop_mode_e    lmode;
  tmop_fault_e        fresp;
  logic signed [15:0] a_lo;
  logic signed [15:0] a_hi;
  logic signed [47:0] num;
  logic signed [47:0] den;
  logic signed [47:0] lin;
  logic [31:0]        i_min;
  logic [31:0]        i_max;
  logic [15:0]        lin_c;
  logic               critical;
  logic [15:0]        cmd;
  assign lmode = tmop_loop_mode_e'(loop_cfg_r[F_LMODE +: 2]);
  assign fresp = tmop_fault_e'(loop_cfg_r[F_FAULT +: 2]);
  assign a_lo  = anchors_r[15:0];
  assign a_hi  = anchors_r[31:16];

  always_comb begin
    // negative denominator inverts
    // Every operand is kept signed so that a negative span divides correctly.
    num = (48'(loop_src) - 48'(a_lo)) * $signed(48'(UA_SPAN));
    den = 48'(a_hi) - 48'(a_lo);
    lin = (den == 48'sd0) ? $signed(48'(UA_4MA)) : num / den + $signed(48'(UA_4MA));
    i_min = 32'(UA_4MA) - (32'(UA_4MA) * 32'(limits_r[8:0])) / 32'd1000;
    i_max = 32'(UA_20MA) + (32'(UA_20MA) * 32'(limits_r[24:16])) / 32'd1000;
    if (i_min < 32'(UA_FLOOR)) begin
      i_min = 32'(UA_FLOOR);
    end
    if (i_max > 32'(UA_CEIL)) begin
      i_max = 32'(UA_CEIL);
    end
    if (lin < $signed(48'(i_min))) begin
      lin_c = i_min[15:0];
    end else if (lin > $signed(48'(i_max))) begin
      lin_c = i_max[15:0];
    end else begin
      lin_c = lin[15:0];
    end
    critical = ((lmode == TMOP_LOOP_4_20) && fault_r) ||
               ((lmode == TMOP_LOOP_BUS) && silence);
    unique case (lmode)
      TMOP_LOOP_4_20: cmd = lin_c;
      TMOP_LOOP_BUS:  cmd = bus_cmd_r;
      default:        cmd = UA_IDLE;
    endcase
  end

  // Loop output register.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      loop_ua_out <= UA_IDLE;
    end else if (new_r || lmode != TMOP_LOOP_4_20) begin
      if (critical) begin
        unique case (fresp)
          TMOP_FAULT_HIGH: loop_ua_out <= UA_HIGHF;
          TMOP_FAULT_LOW:  loop_ua_out <= UA_LOWF;
          default:         loop_ua_out <= loop_ua_out;
        endcase
      end else begin
        loop_ua_out <= cmd;
      end
    end
  end

  // APB read mux.
  always_comb begin
    prdata_out = 32'h0000_0000;
    if (apb_rd) begin
      unique case (paddr_in)
        ADDR_INPUT_CFG: prdata_out = input_cfg_r;
        ADDR_LOOP_CFG:  prdata_out = loop_cfg_r;
        ADDR_ANCHORS:   prdata_out = anchors_r;
        ADDR_LIMITS:    prdata_out = limits_r;
        ADDR_HOLD_CFG:  prdata_out = hold_cfg_r;
        ADDR_SECURITY:  prdata_out = security_r;
        ADDR_BUS_CMD:   prdata_out = {16'h0000, bus_cmd_r};
        ADDR_STATUS:    prdata_out = {24'h000000, trk_r, silence, held_ok_r,
                                      fault_r, menu_open_out, code_ok_r};
        ADDR_VALUES:    prdata_out = {held_r, live_r};
        ADDR_LOOP_OUT:  prdata_out = {16'h0000, loop_ua_out};
        default:        prdata_out = 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- bench/tmop_core_assertions.sv ----
// Port checker for the meter output processor.
// Assumes one 50 MHz clock and an active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module tmop_core_checker
  import tmop_pkg::*;
(
  input wire logic         clock_in,
  input wire logic         reset_in,
  input wire logic         psel_in,
  input wire logic         penable_in,
  input wire logic [7:0]   paddr_in,
  input wire logic [31:0]  prdata_out,
  input wire logic         pready_out,
  input wire logic         pslverr_out,
  input wire tmop_sample_s sample_in,
  input wire logic         result_valid_out,
  input wire logic         range_fault_out,
  input wire logic [15:0]  loop_ua_out
);
  // All checks share the one clock and its reset.
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  a_result_follows: assert property (sample_in.valid |=> result_valid_out)
    else $error("result pulse missing after sample");
  a_result_cause: assert property (result_valid_out |-> $past(sample_in.valid))
    else $error("result pulse without sample");
  a_loop_ceiling: assert property (loop_ua_out <= UA_CEIL)
    else $error("loop current above ceiling");
  a_loop_floor: assert property (loop_ua_out == UA_IDLE || loop_ua_out >= UA_FLOOR)
    else $error("loop current below floor");
  // The fault flag only moves as a sample is processed.
  a_fault_by_sample: assert property ($changed(range_fault_out) |->
    $past(sample_in.valid) || $past(sample_in.valid, 2))
    else $error("fault flag moved without sample");
  a_zero_wait: assert property (psel_in && !penable_in |=> pready_out)
    else $error("access phase not ready");
  a_idle_read: assert property (!(psel_in && penable_in) |-> prdata_out == 32'h0)
    else $error("read data outside access");
  a_bad_addr: assert property (psel_in && penable_in && paddr_in > ADDR_UNLOCK
    |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  c_sample: cover property (sample_in.valid);
  c_fault: cover property ($rose(range_fault_out));
  c_refuse: cover property (pslverr_out);
endmodule
bind tmop_core tmop_core_checker tmop_core_checker_inst (
  .clock_in(clock_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
  .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .sample_in(sample_in), .result_valid_out(result_valid_out),
  .range_fault_out(range_fault_out), .loop_ua_out(loop_ua_out));
`default_nettype wire

// ---- bench/tmop_front_model.sv ----
// Front end model: one compensated sample pulse per send call.
// Assumes send is called right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module tmop_front_model
  import tmop_pkg::*;
(
  input wire logic         clock_in,
  output var tmop_sample_s sample_out
);
  // Outside a pulse the value lines show the inverse, never a stale copy.
  initial sample_out = '0;
  task automatic send(input logic [15:0] v);
    sample_out <= '{1'b1, v};
    @(posedge clock_in);
    sample_out <= '{1'b0, ~v};
    @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

// ---- bench/test_thermo_meter_output_processor.sv ----
// Self-checking bench for the meter output processor over APB.
// Assumes the front end model supplies samples; frames and keys stay idle.
`timescale 1ns/100ps
`default_nettype none
module test_thermo_meter_output_processor;
  import tmop_pkg::*;
  logic         clock_in = 1'b0;
  logic         reset_in = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata, rdata;
  logic         pready, pslverr, err, rvalid, rfault, menu;
  logic [15:0]  loop_ua;
  logic [15:0]  code = 16'h0000;
  logic [1:0]   edit_ok;
  tmop_sample_s sample;
  tmop_route_s  route;
  int           failures = 0;
  int           n_checks = 0;
  tmop_front_model tmop_front_model_inst (.clock_in(clock_in), .sample_out(sample));
  tmop_core tmop_core_inst (.clock_in(clock_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sample_in(sample),
    .frame_seen_in(1'b0), .escape_key_in(1'b0), .entered_code_in(code),
    .route_out(route), .result_valid_out(rvalid), .range_fault_out(rfault),
    .loop_ua_out(loop_ua), .menu_open_out(menu), .threshold_edit_ok_out(edit_ok));
  // Free-running 50 MHz clock and a hang guard.
  initial forever #10 clock_in = ~clock_in;
  initial begin
    repeat (100000) @(posedge clock_in);
    failures++;
    end_sim();
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; data and response are taken at the ready edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      end_sim();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following call from driving psel twice in a time step.
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Send a sample and wait until the loop command has settled.
  task automatic sm(input logic [15:0] v);
    tmop_front_model_inst.send(v);
    repeat (3) @(posedge clock_in);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    chk("reset loop", 32'(loop_ua), 32'(UA_IDLE));
    reset_in <= 1'b0;
    @(posedge clock_in);
    apb(1'b0, ADDR_ANCHORS, 32'h0);
    chk("anchors", rdata, 32'h2710_0000);
    wr(ADDR_ANCHORS, 32'h03E8_0000);
    wr(ADDR_INPUT_CFG, 32'h0000_0020);
    sm(16'h01F4);
    chk("live", 32'(route.shown), 32'h01F4);
    chk("linear", 32'(loop_ua), 32'h2EE0);
    $display("test setup done");
    wr(ADDR_INPUT_CFG, 32'h0000_0000);
    sm(16'h0219);
    chk("whole", 32'(route.shown), 32'h0212);
    wr(ADDR_INPUT_CFG, 32'h0000_0030);
    sm(16'h01F4);
    chk("imperial_temp_scale", 32'(route.shown), 32'h04C4);
    wr(ADDR_INPUT_CFG, 32'h0005_0020);
    sm(16'h01F4);
    chk("shift", 32'(route.shown), 32'h0226);
    wr(ADDR_INPUT_CFG, 32'h0005_0038);
    sm(16'h04D2);
    chk("volt", 32'(route.shown), 32'h04D2);
    $display("test input done");
    wr(ADDR_INPUT_CFG, 32'h0000_0020);
    wr(ADDR_ANCHORS, 32'h0000_03E8);
    sm(16'h00FA);
    chk("invert", 32'(loop_ua), 32'h3E80);
    wr(ADDR_ANCHORS, 32'h03E8_0000);
    wr(ADDR_LIMITS, 32'h0032_0032);
    sm(16'h07D0);
    chk("upper", 32'(loop_ua), 32'h5208);
    sm(16'hFE0C);
    chk("lower", 32'(loop_ua), 32'h0ED8);
    $display("test loop done");
    wr(ADDR_LOOP_CFG, 32'h0000_0005);
    sm(16'h36B0);
    chk("fault", 32'(rfault), 32'h1);
    chk("high f", 32'(loop_ua), 32'(UA_HIGHF));
    wr(ADDR_LOOP_CFG, 32'h0000_0009);
    sm(16'h36B1);
    chk("low f", 32'(loop_ua), 32'(UA_LOWF));
    sm(16'h01F4);
    chk("clear", 32'(loop_ua), 32'h2EE0);
    wr(ADDR_LOOP_CFG, 32'h0000_0001);
    sm(16'h36B0);
    chk("keep", 32'(loop_ua), 32'h2EE0);
    wr(ADDR_LOOP_CFG, 32'h0000_0000);
    repeat (2) @(posedge clock_in);
    chk("off", 32'(loop_ua), 32'(UA_IDLE));
    wr(ADDR_BUS_CMD, 32'h0000_2710);
    wr(ADDR_LOOP_CFG, 32'h0000_0002);
    repeat (2) @(posedge clock_in);
    chk("bus", 32'(loop_ua), 32'h2710);
    $display("test fault done");
    wr(ADDR_LOOP_CFG, 32'h0000_0001);
    sm(16'h012C);
    wr(ADDR_HOLD_CFG, 32'h0064_0A16);
    sm(16'h012C);
    sm(16'h0320);
    sm(16'h02EE);
    chk("small swing", 32'(route.shown), 32'h02EE);
    sm(16'h0258);
    sm(16'h01F4);
    chk("held", 32'(route.shown), 32'h0320);
    chk("relay1", 32'(route.relay1), 32'h0320);
    chk("relay2", 32'(route.relay2), 32'h01F4);
    chk("loop held", 32'(loop_ua), 32'h41A0);
    wr(ADDR_INPUT_CFG, 32'h0000_0120);
    sm(16'h0258);
    chk("smooth", 32'(route.relay2), 32'h0226);
    $display("test hold done");
    wr(ADDR_SECURITY, 32'h0001_1234);
    chk("unlock", 32'(edit_ok), 32'h1);
    chk("locked", {31'h0, menu}, 32'h0);
    wr(ADDR_SECURITY, 32'h0000_0000);
    chk("no code", 32'(edit_ok), 32'h3);
    wr(ADDR_SECURITY, 32'h0000_1234);
    code <= 16'h1234;
    wr(ADDR_UNLOCK, 32'h0);
    chk("code ok", {31'h0, menu}, 32'h1);
    apb(1'b0, 8'h2C, 32'h0);
    chk("refused", {31'h0, err}, 32'h1);
    chk("refused data", rdata, 32'h0);
    $display("test access done");
    end_sim();
  end
endmodule
`default_nettype wire
